// File: src/axis_cmd_pkg.sv
// package of constants and carrier types for the axis command decoder
// assumes a byte-wide frame input from some serial front end on one clock
// ---------------------------------------------------------------
// What this block does
// - frame: address, instruction, type, bank, value msb first, checksum
// - move type 1 adds signed two's-complement offset to current position
// - move type 2 uses value as stored coordinate number, moves there
// - instruction 5 writes value into parameter named by type, replies 100
// - set values live in volatile working memory only
// - instruction 6 replies 100 with selected parameter value
// - get inside a standalone program also copies value to accumulator
// - get from host leaves accumulator unchanged
// - instruction 7 copies parameter to backing store, replies 100 and zero
// - instruction 8 reloads parameter from backing store
// - after reset every parameter loads from backing store before commands
// - move type 0 absolute, 1 relative, 2 stored coordinate
// ---------------------------------------------------------------
package axis_cmd_pkg;
  localparam int FRAME_BYTES = 9;
  localparam logic [7:0] MOVE_TO_POSITION_CMD = 8'h04;
  localparam logic [7:0] SET_AXIS_PARAM_CMD = 8'h05;
  localparam logic [7:0] GET_AXIS_PARAM_CMD = 8'h06;
  localparam logic [7:0] STORE_AXIS_PARAM_CMD = 8'h07;
  localparam logic [7:0] RESTORE_AXIS_PARAM_CMD = 8'h08;
  localparam logic [7:0] ABSOLUTE_TARGET_TYPE = 8'h00;
  localparam logic [7:0] RELATIVE_OFFSET_TYPE = 8'h01;
  localparam logic [7:0] STORED_COORDINATE_TYPE = 8'h02;
  localparam logic [7:0] STATUS_OK = 8'h64;
  localparam logic [7:0] STATUS_BAD_CHECKSUM = 8'h01;
  localparam logic [7:0] STATUS_BAD_CMD = 8'h02;
  localparam logic [7:0] STATUS_BAD_TYPE = 8'h03;
  localparam logic [7:0] STATUS_BAD_VALUE = 8'h04;
  localparam logic [7:0] REPLY_ADDR = 8'h02;
  localparam logic [7:0] MODULE_ADDR = 8'h01;
  localparam logic [3:0] IDX_CSUM = 4'h8;
  localparam logic [3:0] IDX_LAST_VALUE = 4'h7;

  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] instr;
    logic [7:0] ptype;
    logic [7:0] bank;
    logic [31:0] value;
  } cmd_frame_t;

  typedef struct packed {
    logic [7:0] reply_addr;
    logic [7:0] module_addr;
    logic [7:0] status;
    logic [7:0] instr;
    logic [31:0] value;
  } reply_t;

  typedef struct packed {
    logic valid;
    logic [7:0] data;
  } byte_in_t;
endpackage

// File: src/frame_collect.sv
`timescale 1ns/1ps
// byte collector: assembles nine-byte command frames and checks the sum
// assumes bytes arrive on clk as one-cycle strobes, no pin crossing here
module frame_collect (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic in_valid,
  input wire logic [7:0] in_data,
  input wire logic hold,
  output logic frame_valid,
  output logic sum_ok,
  output axis_cmd_pkg::cmd_frame_t frame
);
  import axis_cmd_pkg::*;

  logic [3:0] idx_q, idx_d;
  logic [7:0] sum_q, sum_d;
  logic [63:0] sr_q, sr_d;
  logic fv_q, fv_d;
  logic ok_q, ok_d;

  // ---------------------------------------------------------------
  // byte counting and checksum
  // ---------------------------------------------------------------
  // bytes offered while hold is high are dropped, so the host must wait
  always_comb begin
    idx_d = idx_q;
    sum_d = sum_q;
    sr_d = sr_q;
    fv_d = 1'b0;
    ok_d = ok_q;
    if (in_valid && !hold) begin
      if (idx_q == IDX_CSUM) begin
        fv_d = 1'b1;
        ok_d = (in_data == sum_q);
        idx_d = 4'h0;
        sum_d = 8'h00;
      end else begin
        sr_d = {sr_q[55:0], in_data};
        sum_d = sum_q + in_data;
        idx_d = idx_q + 4'h1;
      end
    end
  end

  // registers only
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      idx_q <= 4'h0;
      sum_q <= 8'h00;
      sr_q <= 64'h0;
      fv_q <= 1'b0;
      ok_q <= 1'b0;
    end else begin
      idx_q <= idx_d;
      sum_q <= sum_d;
      sr_q <= sr_d;
      fv_q <= fv_d;
      ok_q <= ok_d;
    end
  end

  assign frame_valid = fv_q;
  assign sum_ok = ok_q;
  assign frame = cmd_frame_t'(sr_q);

  // a frame is flagged exactly one cycle after its checksum byte
  frame_pulse_a: assert property (@(posedge clk) disable iff (!rst_b)
    in_valid && !hold && idx_q == IDX_CSUM |=> frame_valid)
    else $error("frame strobe missing after checksum byte");
  sum_check_a: assert property (@(posedge clk) disable iff (!rst_b)
    in_valid && !hold && idx_q == IDX_CSUM && in_data != sum_q
    |=> !sum_ok)
    else $error("bad checksum accepted");
endmodule

// File: src/axis_param_command_decoder.sv
`timescale 1ns/1ps
// axis parameter command decoder: executes move, set, get, store, restore
// assumes a byte front end on clk and a nonvolatile copy kept inside
module axis_param_command_decoder #(
  parameter int NUM_PARAMS = 16,
  parameter int NUM_COORDS = 21
) (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic in_valid,
  input wire logic [7:0] in_data,
  input wire logic program_mode,
  input wire logic [31:0] actual_position,
  output logic ready,
  output logic reply_valid,
  output axis_cmd_pkg::reply_t reply,
  output logic target_valid,
  output logic [31:0] target_position,
  output logic [31:0] accumulator
);
  import axis_cmd_pkg::*;

  typedef enum logic [2:0] {
    ST_LOAD = 3'b001,
    ST_IDLE = 3'b010,
    ST_EXEC = 3'b100
  } state_t;

  localparam int PW = $clog2(NUM_PARAMS);
  localparam int CW = $clog2(NUM_COORDS);

  state_t st_q, st_d;
  logic [PW-1:0] load_q, load_d;
  logic [31:0] work_q [NUM_PARAMS];
  logic [31:0] work_d [NUM_PARAMS];
  logic [31:0] nv_q [NUM_PARAMS];
  logic [31:0] nv_d [NUM_PARAMS];
  logic [31:0] stored_coordinate_type_q [NUM_COORDS];
  reply_t rep_q, rep_d;
  logic rv_q, rv_d;
  logic ready_q, ready_d;
  logic tv_q, tv_d;
  logic [31:0] tgt_q, tgt_d;
  logic [31:0] acc_q, acc_d;
  logic frame_valid, sum_ok;
  cmd_frame_t fr;
  logic [PW-1:0] pidx;
  logic [CW-1:0] cidx;
  logic pok, cok;

  // ---------------------------------------------------------------
  // frame assembly
  // ---------------------------------------------------------------
  frame_collect u_collect (
    .clk(clk),
    .rst_b(rst_b),
    .in_valid(in_valid),
    .in_data(in_data),
    .hold(st_q != ST_IDLE),
    .frame_valid(frame_valid),
    .sum_ok(sum_ok),
    .frame(fr)
  );

  assign pidx = fr.ptype[PW-1:0];
  assign cidx = fr.value[CW-1:0];
  assign pok = 32'(fr.ptype) < NUM_PARAMS;
  assign cok = fr.value < 32'(NUM_COORDS);

  // coordinates have no write path in this block; they reset to
  // zero and hold, so every in-range stored coordinate move goes to zero
  generate
    for (genvar c = 0; c < NUM_COORDS; c++) begin : g_stored_coordinate_type
      always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
          stored_coordinate_type_q[c] <= 32'h0;
        end else begin
          stored_coordinate_type_q[c] <= stored_coordinate_type_q[c];
        end
      end
    end
  endgenerate

  // ---------------------------------------------------------------
  // command execution
  // ---------------------------------------------------------------
  // one command per frame; the reply comes two cycles after the frame strobe
  always_comb begin
    st_d = st_q;
    load_d = load_q;
    work_d = work_q;
    nv_d = nv_q;
    rep_d = rep_q;
    rv_d = 1'b0;
    tv_d = 1'b0;
    tgt_d = tgt_q;
    acc_d = acc_q;
    case (st_q)
      ST_LOAD: begin
        work_d[load_q] = nv_q[load_q];
        load_d = load_q + 1'b1;
        if (32'(load_q) == NUM_PARAMS - 1) begin
          st_d = ST_IDLE;
        end
      end
      ST_IDLE: begin
        if (frame_valid) begin
          st_d = ST_EXEC;
        end
      end
      ST_EXEC: begin
        st_d = ST_IDLE;
        rv_d = 1'b1;
        rep_d.reply_addr = REPLY_ADDR;
        rep_d.module_addr = MODULE_ADDR;
        rep_d.instr = fr.instr;
        rep_d.status = STATUS_OK;
        rep_d.value = 32'h0;
        if (!sum_ok) begin
          rep_d.status = STATUS_BAD_CHECKSUM;
        end else begin
          case (fr.instr)
            MOVE_TO_POSITION_CMD: begin
              tv_d = 1'b1;
              case (fr.ptype)
                ABSOLUTE_TARGET_TYPE: tgt_d = fr.value;
                RELATIVE_OFFSET_TYPE: tgt_d = actual_position + fr.value;
                STORED_COORDINATE_TYPE: begin
                  if (cok) begin
                    tgt_d = stored_coordinate_type_q[cidx];
                  end else begin
                    tv_d = 1'b0;
                    rep_d.status = STATUS_BAD_VALUE;
                  end
                end
                default: begin
                  tv_d = 1'b0;
                  rep_d.status = STATUS_BAD_TYPE;
                end
              endcase
            end
            SET_AXIS_PARAM_CMD, GET_AXIS_PARAM_CMD, STORE_AXIS_PARAM_CMD,
            RESTORE_AXIS_PARAM_CMD: begin
              if (!pok) begin
                rep_d.status = STATUS_BAD_TYPE;
              end else if (fr.instr == SET_AXIS_PARAM_CMD) begin
                work_d[pidx] = fr.value;
              end else if (fr.instr == GET_AXIS_PARAM_CMD) begin
                rep_d.value = work_q[pidx];
                if (program_mode) begin
                  acc_d = work_q[pidx];
                end
              end else if (fr.instr == STORE_AXIS_PARAM_CMD) begin
                nv_d[pidx] = work_q[pidx];
              end else begin
                work_d[pidx] = nv_q[pidx];
              end
            end
            default: rep_d.status = STATUS_BAD_CMD;
          endcase
        end
      end
      default: st_d = ST_LOAD;
    endcase
    // ready comes from a flop yet still tracks the idle state exactly
    ready_d = (st_d == ST_IDLE);
  end

  // registers only; the backing copy keeps its content across soft resets
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      st_q <= ST_LOAD;
      load_q <= '0;
      rep_q <= '0;
      rv_q <= 1'b0;
      ready_q <= 1'b0;
      tv_q <= 1'b0;
      tgt_q <= 32'h0;
      acc_q <= 32'h0;
      for (int i = 0; i < NUM_PARAMS; i++) begin
        work_q[i] <= 32'h0;
      end
    end else begin
      st_q <= st_d;
      load_q <= load_d;
      rep_q <= rep_d;
      rv_q <= rv_d;
      ready_q <= ready_d;
      tv_q <= tv_d;
      tgt_q <= tgt_d;
      acc_q <= acc_d;
      work_q <= work_d;
    end
  end

  // nonvolatile copy: no reset, like a real backing store
  always_ff @(posedge clk) begin
    nv_q <= nv_d;
  end

  assign ready = ready_q;
  assign reply_valid = rv_q;
  assign reply = rep_q;
  assign target_valid = tv_q;
  assign target_position = tgt_q;
  assign accumulator = acc_q;

  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------
  rel_target_a: assert property (@(posedge clk) disable iff (!rst_b)
    st_q == ST_EXEC && sum_ok && fr.instr == MOVE_TO_POSITION_CMD &&
    fr.ptype == RELATIVE_OFFSET_TYPE
    |=> target_valid && target_position ==
    $past(actual_position) + $past(fr.value))
    else $error("relative move target wrong");
  set_ok_a: assert property (@(posedge clk) disable iff (!rst_b)
    st_q == ST_EXEC && sum_ok && fr.instr == SET_AXIS_PARAM_CMD && pok
    |=> reply_valid && reply.status == STATUS_OK)
    else $error("set reply not ok");
  get_value_a: assert property (@(posedge clk) disable iff (!rst_b)
    st_q == ST_EXEC && sum_ok && fr.instr == GET_AXIS_PARAM_CMD && pok
    |=> reply.value == $past(work_q[pidx]))
    else $error("get reply value wrong");
  acc_direct_a: assert property (@(posedge clk) disable iff (!rst_b)
    !program_mode |=> $stable(accumulator))
    else $error("accumulator changed by host get");
  acc_program_a: assert property (@(posedge clk) disable iff (!rst_b)
    st_q == ST_EXEC && sum_ok && fr.instr == GET_AXIS_PARAM_CMD && pok &&
    program_mode |=> accumulator == reply.value)
    else $error("accumulator not loaded in program");
  store_zero_a: assert property (@(posedge clk) disable iff (!rst_b)
    st_q == ST_EXEC && sum_ok && fr.instr == STORE_AXIS_PARAM_CMD
    |=> reply_valid && reply.value == 32'h0)
    else $error("store reply value not zero");
  restore_work_a: assert property (@(posedge clk) disable iff (!rst_b)
    st_q == ST_EXEC && sum_ok && fr.instr == RESTORE_AXIS_PARAM_CMD && pok
    |=> work_q[$past(pidx)] == $past(nv_q[pidx]))
    else $error("restore did not reload");
  boot_load_a: assert property (@(posedge clk) disable iff (!rst_b)
    st_q == ST_LOAD |-> !ready && !reply_valid)
    else $error("command accepted during load");
  bad_sum_a: assert property (@(posedge clk) disable iff (!rst_b)
    st_q == ST_EXEC && !sum_ok
    |=> reply.status == STATUS_BAD_CHECKSUM && !target_valid)
    else $error("bad frame executed");
endmodule

// File: verification/host_model.sv
`timescale 1ns/1ps
// host side model: sends nine-byte command frames as byte strobes
// assumes the caller waits for ready before each frame
module host_model (
  input wire logic clk,
  output logic in_valid,
  output logic [7:0] in_data
);
  import axis_cmd_pkg::*;
  // ----------------------------------------------
  // idle levels
  // ----------------------------------------------
  initial begin
    in_valid = 1'b0;
    in_data = 8'h00;
  end
  // ----------------------------------------------
  // frame sender
  // ----------------------------------------------
  // bytes go out back to back on falling edges; bad corrupts the sum
  task automatic send(input cmd_frame_t f, input logic bad);
    logic [7:0] b [FRAME_BYTES];
    logic [7:0] sum;
    int i;
    b[0] = f.addr;
    b[1] = f.instr;
    b[2] = f.ptype;
    b[3] = f.bank;
    for (i = 0; i < 4; i++) begin
      b[4 + i] = f.value[31 - 8 * i -: 8];
    end
    sum = 8'h00;
    for (i = 0; i < 8; i++) begin
      sum = sum + b[i];
    end
    b[8] = bad ? ~sum : sum;
    for (i = 0; i < FRAME_BYTES; i++) begin
      @(negedge clk);
      in_valid <= 1'b1;
      in_data <= b[i];
    end
    @(negedge clk);
    in_valid <= 1'b0;
    // released line shows the inverse so stale data never looks valid
    in_data <= ~b[8];
  endtask
endmodule

// File: verification/tb_top.sv
`timescale 1ns/1ps
// self-checking bench for the axis command decoder
// assumes the host model in its own file and default parameters
`define CHK(got, exp) begin \
  total_checks++; \
  if ((got) !== (exp)) begin \
    n_mismatch++; \
    $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp); \
  end \
end
module tb_top;
  import axis_cmd_pkg::*;
  logic clk, rst_b, in_valid, program_mode, ready, reply_valid;
  logic target_valid, tv;
  logic [7:0] in_data;
  logic [31:0] actual_position, target_position, accumulator;
  reply_t reply, rep;
  int n_mismatch = 0;
  int total_checks = 0;
  // ----------------------------------------------
  // design and host
  // ----------------------------------------------
  axis_param_command_decoder axis_param_command_decoder_i (
    .clk(clk), .rst_b(rst_b), .in_valid(in_valid), .in_data(in_data),
    .program_mode(program_mode), .actual_position(actual_position),
    .ready(ready), .reply_valid(reply_valid), .reply(reply),
    .target_valid(target_valid), .target_position(target_position),
    .accumulator(accumulator));
  host_model host_model_i (.clk(clk), .in_valid(in_valid),
    .in_data(in_data));
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  // ----------------------------------------------
  // shared tasks
  // ----------------------------------------------
  task automatic end_sim();
    $display("mismatches %0d checks %0d", n_mismatch, total_checks);
    if (n_mismatch == 0 && total_checks > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask
  // one frame in, one reply captured in the cycle it stands
  task automatic cmd(input logic [7:0] i, input logic [7:0] t,
                     input logic [31:0] v, input logic bad);
    int k;
    k = 0;
    while (ready !== 1'b1 && k < 50) begin
      @(negedge clk);
      k++;
    end
    if (k == 50) begin
      n_mismatch++;
      end_sim();
    end
    host_model_i.send(cmd_frame_t'{MODULE_ADDR, i, t, 8'h00, v}, bad);
    k = 0;
    while (reply_valid !== 1'b1 && k < 20) begin
      @(negedge clk);
      k++;
    end
    if (k == 20) begin
      n_mismatch++;
      end_sim();
    end
    rep = reply;
    tv = target_valid;
  endtask
  // ----------------------------------------------
  // scenarios
  // ----------------------------------------------
  task automatic t_boot();
    int k;
    `CHK(ready, 1'b0)
    k = 0;
    while (ready !== 1'b1 && k < 40) begin
      @(negedge clk);
      k++;
    end
    `CHK(ready, 1'b1)
    if (k == 40) begin
      end_sim();
    end
  endtask
  task automatic t_set_get();
    cmd(SET_AXIS_PARAM_CMD, 8'h03, 32'h12345678, 1'b0);
    `CHK(rep.status, STATUS_OK)
    `CHK(rep.instr, SET_AXIS_PARAM_CMD)
    `CHK(rep.reply_addr, REPLY_ADDR)
    `CHK(rep.module_addr, MODULE_ADDR)
    cmd(SET_AXIS_PARAM_CMD, 8'h0F, 32'hA5A5C3C3, 1'b0);
    cmd(GET_AXIS_PARAM_CMD, 8'h03, 32'h00000000, 1'b0);
    `CHK(rep.status, STATUS_OK)
    `CHK(rep.value, 32'h12345678)
    `CHK(accumulator, 32'h00000000)
    cmd(SET_AXIS_PARAM_CMD, 8'h10, 32'h00000001, 1'b0);
    `CHK(rep.status, STATUS_BAD_TYPE)
  endtask
  task automatic t_program_get();
    program_mode = 1'b1;
    cmd(GET_AXIS_PARAM_CMD, 8'h0F, 32'h00000000, 1'b0);
    `CHK(rep.value, 32'hA5A5C3C3)
    `CHK(accumulator, 32'hA5A5C3C3)
    program_mode = 1'b0;
  endtask
  task automatic t_store_restore();
    cmd(STORE_AXIS_PARAM_CMD, 8'h03, 32'hFFFFFFFF, 1'b0);
    `CHK(rep.status, STATUS_OK)
    `CHK(rep.value, 32'h00000000)
    cmd(SET_AXIS_PARAM_CMD, 8'h03, 32'h0BADF00D, 1'b0);
    cmd(RESTORE_AXIS_PARAM_CMD, 8'h03, 32'h00000001, 1'b0);
    `CHK(rep.status, STATUS_OK)
    cmd(GET_AXIS_PARAM_CMD, 8'h03, 32'h00000000, 1'b0);
    `CHK(rep.value, 32'h12345678)
  endtask
  task automatic t_moves();
    actual_position = 32'h00002710;
    cmd(MOVE_TO_POSITION_CMD, RELATIVE_OFFSET_TYPE, 32'hFFFFD8F0, 1'b0);
    `CHK(tv, 1'b1)
    `CHK(target_position, 32'h00000000)
    cmd(MOVE_TO_POSITION_CMD, ABSOLUTE_TARGET_TYPE, 32'h00015F90, 1'b0);
    `CHK(target_position, 32'h00015F90)
    // every coordinate is defined as zero from reset, so the host may use it
    cmd(MOVE_TO_POSITION_CMD, STORED_COORDINATE_TYPE, 32'h00000008,
        1'b0);
    `CHK(tv, 1'b1)
    `CHK(target_position, 32'h00000000)
    cmd(MOVE_TO_POSITION_CMD, STORED_COORDINATE_TYPE, 32'h00000015, 1'b0);
    `CHK(rep.status, STATUS_BAD_VALUE)
    `CHK(tv, 1'b0)
    cmd(MOVE_TO_POSITION_CMD, 8'h03, 32'h00000001, 1'b0);
    `CHK(rep.status, STATUS_BAD_TYPE)
  endtask
  task automatic t_bad_sum();
    cmd(SET_AXIS_PARAM_CMD, 8'h03, 32'h00000055, 1'b1);
    `CHK(rep.status, STATUS_BAD_CHECKSUM)
    cmd(MOVE_TO_POSITION_CMD, ABSOLUTE_TARGET_TYPE, 32'h00000007, 1'b1);
    `CHK(tv, 1'b0)
    cmd(GET_AXIS_PARAM_CMD, 8'h03, 32'h00000000, 1'b0);
    `CHK(rep.value, 32'h12345678)
    cmd(8'h09, 8'h00, 32'h00000000, 1'b0);
    `CHK(rep.status, STATUS_BAD_CMD)
  endtask
  // a mid-run reset drops working values and reloads the stored copy
  task automatic t_reboot();
    int k;
    cmd(SET_AXIS_PARAM_CMD, 8'h03, 32'h0BADF00D, 1'b0);
    @(negedge clk);
    rst_b = 1'b0;
    repeat (2) @(negedge clk);
    rst_b = 1'b1;
    `CHK(ready, 1'b0)
    k = 0;
    while (ready !== 1'b1 && k < 40) begin
      @(negedge clk);
      k++;
    end
    `CHK(ready, 1'b1)
    if (k == 40) begin
      end_sim();
    end
    cmd(GET_AXIS_PARAM_CMD, 8'h03, 32'h00000000, 1'b0);
    `CHK(rep.status, STATUS_OK)
    `CHK(rep.value, 32'h12345678)
  endtask
  // ----------------------------------------------
  // main sequence
  // ----------------------------------------------
  initial begin
    rst_b = 1'b0;
    program_mode = 1'b0;
    actual_position = 32'h00000000;
    repeat (2) @(negedge clk);
    rst_b = 1'b1;
    t_boot();
    t_set_get();
    t_program_get();
    t_store_restore();
    t_moves();
    t_bad_sum();
    t_reboot();
    end_sim();
  end
endmodule
